// ===== hdl/ibt_params.svh
// Purpose: shared offsets, widths and timing counts of the issue block
// Assumes: included by bare name; definitions only
// Notes: all cycle counts are core clock cycles (200 MHz, 5 ns)
`ifndef IBT_PARAMS_SVH
`define IBT_PARAMS_SVH

`define IBT_NUM_GPR 32
`define IBT_GPR_W 5
`define IBT_NUM_CRF 8
`define IBT_CRF_W 3
`define IBT_CNT_W 2
`define IBT_REC_CRF 3'h0
`define IBT_LAT_SIMPLE 1
`define IBT_RR_SIMPLE 1
`define IBT_LAT_BRANCH 1
`define IBT_RR_BRANCH 1
`define IBT_LAT_CMP_EQ 1
`define IBT_LAT_CMP_REST 2
`define IBT_SECONDARY_EXTRA 1
`define IBT_NUM_UNITS 3
`define IBT_UNIT_A 0
`define IBT_UNIT_B 1
`define IBT_UNIT_BR 2

`endif

// ===== hdl/ibt_pkg.sv
// Purpose: types of the integer/branch issue block
// Assumes: nothing
// Notes: op classes group instructions of equal routing and timing
package ibt_pkg;
    typedef enum logic [2:0] {
        IBT_OP_ADD,
        IBT_OP_AND,
        IBT_OP_CMP,
        IBT_OP_CLZ,
        IBT_OP_BR,
        IBT_OP_CRL,
        IBT_OP_COMP
    } ibt_op_e;
endpackage

// ===== hdl/ibt_unit_if.sv
// Purpose: issue/start/done handshake between issue logic and a unit timer
// Assumes: single core clock
// Notes: issue is a one-cycle pulse, start follows it by one cycle
`timescale 1ns/1ps
interface ibt_unit_if;
    logic issue;
    logic can_issue;
    logic start;
    logic done;
    modport ctl (output issue, input can_issue, input start, input done);
    modport unit (input issue, output can_issue, output start, output done);
endinterface // ibt_unit_if

// ===== hdl/ibt_unit_timer.sv
// Purpose: repeat-rate gate and latency pipe of one execution unit
// Assumes: issue only while can_issue is high
// Notes: with repeat rate 1 the unit is fully pipelined at any latency
`timescale 1ns/1ps
module ibt_unit_timer #(
    parameter int LAT = 1,
    parameter int RR = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    ibt_unit_if.unit u
);
    localparam int RW = (RR > 1) ? $clog2(RR) : 1;

    // elaboration-time refusal of settings the counters cannot hold
    if (LAT < 1 || RR < 1 || LAT > 64 || RR > 64) begin : g_bad_cfg
        $error("ibt_unit_timer: LAT and RR must lie in 1..64");
    end

    logic [RW-1:0] rr_cnt;
    logic [RW-1:0] next_rr_cnt;
    logic start;
    logic [LAT-1:0] pipe;
    logic [LAT-1:0] next_pipe;

    always_comb begin
        next_rr_cnt = (rr_cnt != '0) ? rr_cnt - 1'b1 : rr_cnt;
        if (u.issue) begin
            next_rr_cnt = RW'(RR - 1);
        end
        next_pipe = LAT'({pipe, start}); // oldest stage drops out on purpose
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rr_cnt <= '0;
            start <= 1'b0;
            pipe <= '0;
        end else begin
            rr_cnt <= next_rr_cnt;
            start <= u.issue;
            pipe <= next_pipe;
        end
    end

    assign u.can_issue = (rr_cnt == '0);
    assign u.start = start;
    assign u.done = pipe[LAT-1];

    property p_rr_gap;
        @(posedge sys_clk) disable iff (!nrst)
        u.issue |=> (RR == 1) ? u.can_issue : !u.can_issue;
    endproperty
    a_rr_gap: assert property (p_rr_gap)
        else $error("unit repeat gate wrong after issue");

    property p_lat;
        @(posedge sys_clk) disable iff (!nrst)
        start && LAT == 1 |=> u.done;
    endproperty
    a_lat: assert property (p_lat)
        else $error("unit result not delivered after latency");
endmodule // ibt_unit_timer

// ===== hdl/ibt_issue.sv
// Purpose: routes integer, branch and completion-handled ops and times them
// Assumes: one request per cycle from dispatch; valid/ready handshake
// Notes: scoreboard counts cycles until each result may feed a dependent
// Functional notes
// - ops for both simple units go to whichever unit is free
// - completion-handled ops reach no unit; completion performs them
// - latency runs from unit start to primary result, nothing else
// - flags and recording condition field come one cycle after result
// - a unit starts again only after its repeat interval; rate 1 pipelined
// - all add forms use either simple unit, rate 1, latency 1
// - and forms use either simple unit, rate 1, latency 1
// - compares: either simple unit; equal bit after 1, rest after 2
// - count-leading-zeros goes only to the first simple unit
`timescale 1ns/1ps
`include "ibt_params.svh"
module ibt_issue (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    output logic req_ready,
    input wire ibt_pkg::ibt_op_e req_op,
    input wire logic req_use_src_a,
    input wire logic [`IBT_GPR_W-1:0] req_src_a,
    input wire logic req_use_src_b,
    input wire logic [`IBT_GPR_W-1:0] req_src_b,
    input wire logic req_wr_gpr,
    input wire logic [`IBT_GPR_W-1:0] req_dst,
    input wire logic req_rec,
    input wire logic req_ovf,
    input wire logic req_use_ovf,
    input wire logic req_use_crf,
    input wire logic req_eq_only,
    input wire logic [`IBT_CRF_W-1:0] req_crf,
    output logic unit_a_start,
    output logic unit_b_start,
    output logic branch_start,
    output logic unit_a_done,
    output logic unit_b_done,
    output logic branch_done,
    output logic comp_exec,
    output logic [`IBT_CNT_W-1:0] crf_rest_wait0
);
    import ibt_pkg::*;

    localparam logic [`IBT_CNT_W-1:0] W_SIMPLE = `IBT_CNT_W'(`IBT_LAT_SIMPLE - 1);
    localparam logic [`IBT_CNT_W-1:0] W_BRANCH = `IBT_CNT_W'(`IBT_LAT_BRANCH - 1);
    localparam logic [`IBT_CNT_W-1:0] W_CMP_EQ = `IBT_CNT_W'(`IBT_LAT_CMP_EQ - 1);
    localparam logic [`IBT_CNT_W-1:0] W_CMP_REST =
        `IBT_CNT_W'(`IBT_LAT_CMP_REST - 1);
    localparam logic [`IBT_CNT_W-1:0] W_SECOND =
        `IBT_CNT_W'(`IBT_LAT_SIMPLE - 1 + `IBT_SECONDARY_EXTRA);

    ibt_unit_if ui [`IBT_NUM_UNITS] ();

    genvar g;
    generate
        for (g = 0; g < `IBT_NUM_UNITS; g++) begin : g_unit
            ibt_unit_timer #(
                .LAT((g == `IBT_UNIT_BR) ? `IBT_LAT_BRANCH : `IBT_LAT_SIMPLE),
                .RR((g == `IBT_UNIT_BR) ? `IBT_RR_BRANCH : `IBT_RR_SIMPLE)
            ) u_timer (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .u(ui[g])
            );
        end
    endgenerate

    logic [`IBT_CNT_W-1:0] gpr_wait [`IBT_NUM_GPR];
    logic [`IBT_CNT_W-1:0] next_gpr_wait [`IBT_NUM_GPR];
    logic [`IBT_CNT_W-1:0] crf_eq_wait [`IBT_NUM_CRF];
    logic [`IBT_CNT_W-1:0] next_crf_eq_wait [`IBT_NUM_CRF];
    logic [`IBT_CNT_W-1:0] crf_rest_wait [`IBT_NUM_CRF];
    logic [`IBT_CNT_W-1:0] next_crf_rest_wait [`IBT_NUM_CRF];
    logic [`IBT_CNT_W-1:0] ovf_wait;
    logic [`IBT_CNT_W-1:0] next_ovf_wait;
    logic comp_q;
    logic next_comp_q;

    logic a_free;
    logic b_free;
    logic br_free;
    logic srcs_ok;
    logic unit_ok;
    logic accept;
    logic to_a;
    logic to_b;
    logic to_br;
    logic simple_any;
    logic a_taken;

    assign a_free = ui[`IBT_UNIT_A].can_issue;
    assign b_free = ui[`IBT_UNIT_B].can_issue;
    assign br_free = ui[`IBT_UNIT_BR].can_issue;
    assign a_taken = ui[`IBT_UNIT_A].start;
    assign simple_any = (req_op == IBT_OP_ADD) || (req_op == IBT_OP_AND) ||
                        (req_op == IBT_OP_CMP);

    // secondary results lag by one cycle, so readers wait on their own count
    always_comb begin
        srcs_ok = 1'b1;
        if (req_use_src_a && gpr_wait[req_src_a] != '0)
            srcs_ok = 1'b0;
        if (req_use_src_b && gpr_wait[req_src_b] != '0)
            srcs_ok = 1'b0;
        if (req_use_ovf && ovf_wait != '0)
            srcs_ok = 1'b0;
        if (req_use_crf && crf_eq_wait[req_crf] != '0)
            srcs_ok = 1'b0;
        if (req_use_crf && !req_eq_only && crf_rest_wait[req_crf] != '0)
            srcs_ok = 1'b0;
    end

    always_comb begin
        to_a = 1'b0;
        to_b = 1'b0;
        to_br = 1'b0;
        unit_ok = 1'b0;
        case (req_op)
            IBT_OP_ADD, IBT_OP_AND, IBT_OP_CMP: begin
                // alternate after an A start, so both units carry work
                unit_ok = a_free || b_free;
                to_b = b_free && (!a_free || a_taken);
                to_a = a_free && !to_b;
            end
            IBT_OP_CLZ: begin
                unit_ok = a_free;
                to_a = a_free;
            end
            IBT_OP_BR, IBT_OP_CRL: begin
                unit_ok = br_free;
                to_br = br_free;
            end
            IBT_OP_COMP: begin
                unit_ok = 1'b1;
            end
            default: begin
                unit_ok = 1'b0;
            end
        endcase
    end

    assign req_ready = srcs_ok && unit_ok;
    assign accept = req_valid && req_ready;
    assign ui[`IBT_UNIT_A].issue = accept && to_a;
    assign ui[`IBT_UNIT_B].issue = accept && to_b;
    assign ui[`IBT_UNIT_BR].issue = accept && to_br;

    always_comb begin
        for (int i = 0; i < `IBT_NUM_GPR; i++) begin
            next_gpr_wait[i] = (gpr_wait[i] != '0) ?
                gpr_wait[i] - 1'b1 : gpr_wait[i];
        end
        for (int i = 0; i < `IBT_NUM_CRF; i++) begin
            next_crf_eq_wait[i] = (crf_eq_wait[i] != '0) ?
                crf_eq_wait[i] - 1'b1 : crf_eq_wait[i];
            next_crf_rest_wait[i] = (crf_rest_wait[i] != '0) ?
                crf_rest_wait[i] - 1'b1 : crf_rest_wait[i];
        end
        next_ovf_wait = (ovf_wait != '0) ? ovf_wait - 1'b1 : ovf_wait;
        next_comp_q = accept && (req_op == IBT_OP_COMP);
        if (accept && req_op != IBT_OP_COMP) begin
            if (req_wr_gpr)
                next_gpr_wait[req_dst] = W_SIMPLE;
            if (req_ovf)
                next_ovf_wait = W_SECOND;
            if (req_rec) begin
                next_crf_eq_wait[`IBT_REC_CRF] = W_SECOND;
                next_crf_rest_wait[`IBT_REC_CRF] = W_SECOND;
            end
            if (req_op == IBT_OP_CMP) begin
                next_crf_eq_wait[req_crf] = W_CMP_EQ;
                next_crf_rest_wait[req_crf] = W_CMP_REST;
            end
            if (req_op == IBT_OP_CRL) begin
                next_crf_eq_wait[req_crf] = W_BRANCH;
                next_crf_rest_wait[req_crf] = W_BRANCH;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `IBT_NUM_GPR; i++)
                gpr_wait[i] <= '0;
            for (int i = 0; i < `IBT_NUM_CRF; i++) begin
                crf_eq_wait[i] <= '0;
                crf_rest_wait[i] <= '0;
            end
            ovf_wait <= '0;
            comp_q <= 1'b0;
        end else begin
            gpr_wait <= next_gpr_wait;
            crf_eq_wait <= next_crf_eq_wait;
            crf_rest_wait <= next_crf_rest_wait;
            ovf_wait <= next_ovf_wait;
            comp_q <= next_comp_q;
        end
    end

    assign unit_a_start = ui[`IBT_UNIT_A].start;
    assign unit_b_start = ui[`IBT_UNIT_B].start;
    assign branch_start = ui[`IBT_UNIT_BR].start;
    assign unit_a_done = ui[`IBT_UNIT_A].done;
    assign unit_b_done = ui[`IBT_UNIT_B].done;
    assign branch_done = ui[`IBT_UNIT_BR].done;
    assign comp_exec = comp_q;
    assign crf_rest_wait0 = crf_rest_wait[0];

    property p_either_unit;
        @(posedge sys_clk) disable iff (!nrst)
        accept && simple_any && b_free && (!a_free || a_taken) |=>
            unit_b_start && !unit_a_start;
    endproperty
    a_either_unit: assert property (p_either_unit)
        else $error("simple op not sent to free second unit");

    property p_comp;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_COMP |=>
            comp_exec && !unit_a_start && !unit_b_start && !branch_start;
    endproperty
    a_comp: assert property (p_comp)
        else $error("completion-handled op reached a unit");

    property p_rec_lag;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_rec && req_op != IBT_OP_COMP |=>
            crf_rest_wait[0] == 2'h1 ##1 crf_rest_wait[0] == 2'h0;
    endproperty
    a_rec_lag: assert property (p_rec_lag)
        else $error("recording field not one cycle behind result");

    property p_add;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_ADD |=>
            (unit_a_start ^ unit_b_start) && !branch_start ##1
            (unit_a_done || unit_b_done);
    endproperty
    a_add: assert property (p_add)
        else $error("add op misrouted or late");

    property p_and;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_AND |=>
            (unit_a_start ^ unit_b_start) && !branch_start;
    endproperty
    a_and: assert property (p_and)
        else $error("and op misrouted");

    property p_branch;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_BR |=>
            branch_start && !unit_a_start && !unit_b_start ##1 branch_done;
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch not timed in branch unit");

    property p_cmp;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_CMP && req_crf == 3'h0 |=>
            crf_eq_wait[0] == 2'h0 && crf_rest_wait[0] == 2'h1;
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare result timing wrong");

    property p_clz;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_CLZ |=> unit_a_start && !unit_b_start;
    endproperty
    a_clz: assert property (p_clz)
        else $error("leading-zero op left first unit");

    property p_crl;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_op == IBT_OP_CRL |=> branch_start && !unit_a_start;
    endproperty
    a_crl: assert property (p_crl)
        else $error("condition logic op not in branch unit");

    property p_hold;
        @(posedge sys_clk) disable iff (!nrst)
        accept && req_ovf && req_op != IBT_OP_COMP |=>
            !(req_use_ovf && req_ready);
    endproperty
    a_hold: assert property (p_hold)
        else $error("dependent op issued before source ready");
endmodule // ibt_issue

// ===== test/ibt_disp_model.sv
// Purpose: dispatch side model offering one op at a time to the issue block
// Assumes: calls start at a falling clock edge
// Notes: idle fields are flipped so a stale op never looks valid
`timescale 1ns/1ps
`include "ibt_params.svh"
module ibt_disp_model (
    input wire logic sys_clk,
    input wire logic req_ready,
    output logic req_valid,
    output ibt_pkg::ibt_op_e req_op,
    output logic req_use_src_a,
    output logic [`IBT_GPR_W-1:0] req_src_a,
    output logic req_use_src_b,
    output logic [`IBT_GPR_W-1:0] req_src_b,
    output logic req_wr_gpr,
    output logic [`IBT_GPR_W-1:0] req_dst,
    output logic req_rec,
    output logic req_ovf,
    output logic req_use_ovf,
    output logic req_use_crf,
    output logic req_eq_only,
    output logic [`IBT_CRF_W-1:0] req_crf,
    output logic hung
);
    import ibt_pkg::*;
    initial begin
        {req_valid, req_use_src_a, req_use_src_b, req_wr_gpr} = 4'h0;
        {req_rec, req_ovf, req_use_ovf, req_use_crf, req_eq_only} = 5'h00;
        {req_src_a, req_src_b, req_dst, req_crf, hung} = '0;
        req_op = IBT_OP_ADD;
    end
    // holds the op until taken; w counts refused cycles
    task automatic send(input ibt_op_e op, input logic ua = 1'b0,
        input logic [4:0] sa = 5'h00, input logic wr = 1'b0,
        input logic [4:0] dst = 5'h00, input logic rec = 1'b0,
        input logic ovf = 1'b0, input logic uovf = 1'b0,
        input logic ucrf = 1'b0, input logic eq = 1'b0,
        input logic [2:0] crf = 3'h0, input logic ub = 1'b0,
        input logic [4:0] sb = 5'h00, output int w);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_op = op;
        {req_use_src_a, req_src_a, req_wr_gpr, req_dst} = {ua, sa, wr, dst};
        {req_rec, req_ovf, req_use_ovf} = {rec, ovf, uovf};
        {req_use_crf, req_eq_only, req_crf} = {ucrf, eq, crf};
        {req_use_src_b, req_src_b} = {ub, sb};
        #1;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        if (n >= 20) hung = 1'b1;
        w = n;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic idle();
        req_valid = 1'b0;
        req_src_a = ~req_src_a;
        req_src_b = ~req_src_b;
        req_dst = ~req_dst;
        req_crf = ~req_crf;
    endtask
endmodule // ibt_disp_model

// ===== test/tb_integer_branch_issue_timing.sv
// Purpose: self-checking bench of the integer/branch issue block
// Assumes: inputs change on the falling edge
// Notes: outputs are sampled at the falling edge, where they are settled
`timescale 1ns/1ps
`include "ibt_params.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
    mismatches++; end end
module tb_integer_branch_issue_timing;
    import ibt_pkg::*;
    logic sys_clk, nrst, req_valid, req_ready, hung;
    ibt_op_e req_op;
    logic ua, ub, wr, rec, ovf, uovf, ucrf, eq;
    logic [4:0] sa, sb, dst;
    logic [2:0] crf;
    logic a_st, b_st, br_st, a_dn, b_dn, br_dn, comp;
    logic [1:0] wait0;
    int mismatches = 0;
    int cmp_count = 0;
    int w;
    ibt_disp_model disp (.sys_clk(sys_clk), .req_ready(req_ready),
        .req_valid(req_valid), .req_op(req_op), .req_use_src_a(ua),
        .req_src_a(sa), .req_use_src_b(ub), .req_src_b(sb),
        .req_wr_gpr(wr), .req_dst(dst), .req_rec(rec), .req_ovf(ovf),
        .req_use_ovf(uovf), .req_use_crf(ucrf), .req_eq_only(eq),
        .req_crf(crf), .hung(hung));
    ibt_issue DUT (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_use_src_a(ua),
        .req_src_a(sa), .req_use_src_b(ub), .req_src_b(sb),
        .req_wr_gpr(wr), .req_dst(dst), .req_rec(rec), .req_ovf(ovf),
        .req_use_ovf(uovf), .req_use_crf(ucrf), .req_eq_only(eq),
        .req_crf(crf), .unit_a_start(a_st), .unit_b_start(b_st),
        .branch_start(br_st), .unit_a_done(a_dn), .unit_b_done(b_dn),
        .branch_done(br_dn), .comp_exec(comp), .crf_rest_wait0(wait0));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge hung) begin
        mismatches++;
        wrap_up();
    end
    // every class once: simple ops start and finish on unit A, branch ops on the branch unit, completion ops on none
    task automatic s_route();
        ibt_op_e op;
        logic c;
        for (int i = 0; i < 7; i++) begin
            op = ibt_op_e'(i);
            c = (op == IBT_OP_COMP);
            disp.send(.op(op), .w(w));
            `CHK("a_start", (op <= IBT_OP_CLZ), a_st)
            `CHK("b_start", 1'b0, b_st)
            `CHK("br_start", (op == IBT_OP_BR || op == IBT_OP_CRL), br_st)
            `CHK("comp_exec", (op == IBT_OP_COMP), comp)
            disp.idle();
            @(negedge sys_clk);
            `CHK("a_done", (op <= IBT_OP_CLZ), a_dn)
            `CHK("br_done", (op == IBT_OP_BR || op == IBT_OP_CRL), br_dn)
            `CHK("comp_no_unit", 1'b0, c & (a_dn | b_dn | br_dn))
            `CHK("b_done", 1'b0, b_dn)
        end
    endtask
    // back-to-back independent adds, one start per cycle
    task automatic s_pipe();
        for (int i = 0; i < 4; i++) begin
            disp.send(.op(IBT_OP_ADD), .wr(1'b1), .dst(5'(i + 8)), .w(w));
            `CHK("pipe_wait", 0, w)
            `CHK("pipe_start", (i % 2 == 0), a_st)
            `CHK("pipe_start_b", (i % 2 == 1), b_st)
        end
        disp.idle();
        @(negedge sys_clk);
        `CHK("pipe_done", 1'b1, b_dn)
        `CHK("pipe_done_a", 1'b0, a_dn)
    endtask
    // producer then consumer with no gap; refused cycles counted
    task automatic s_dep();
        disp.send(.op(IBT_OP_ADD), .wr(1'b1), .dst(5'h03), .w(w));
        disp.send(.op(IBT_OP_ADD), .ua(1'b1), .sa(5'h03), .w(w));
        `CHK("gpr_wait", 0, w)
        disp.send(.op(IBT_OP_ADD), .ub(1'b1), .sb(5'h03), .w(w));
        `CHK("gpr_wait_b", 0, w)
        disp.send(.op(IBT_OP_ADD), .ovf(1'b1), .w(w));
        disp.send(.op(IBT_OP_ADD), .uovf(1'b1), .w(w));
        `CHK("ovf_wait", 1, w)
        disp.send(.op(IBT_OP_AND), .rec(1'b1), .w(w));
        disp.send(.op(IBT_OP_BR), .ucrf(1'b1), .w(w));
        `CHK("rec_wait", 1, w)
        disp.send(.op(IBT_OP_CMP), .w(w));
        `CHK("rest_wait0", 2'h1, wait0)
        disp.send(.op(IBT_OP_BR), .ucrf(1'b1), .eq(1'b1), .w(w));
        `CHK("eq_wait", 0, w)
        disp.send(.op(IBT_OP_CMP), .w(w));
        disp.send(.op(IBT_OP_BR), .ucrf(1'b1), .w(w));
        `CHK("rest_wait", 1, w)
        disp.send(.op(IBT_OP_CMP), .crf(3'h5), .w(w));
        disp.send(.op(IBT_OP_CRL), .ucrf(1'b1), .crf(3'h5), .w(w));
        `CHK("crf5_wait", 1, w)
        disp.idle();
        @(negedge sys_clk);
    endtask
    // reset in mid-flight clears pending waits and pulses
    task automatic s_reset();
        disp.send(.op(IBT_OP_CMP), .w(w));
        disp.idle();
        nrst = 1'b0;
        #1;
        `CHK("rst_wait0", 2'h0, wait0)
        `CHK("rst_ready", 1'b1, req_ready)
        `CHK("rst_start", 1'b0, a_st)
        @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
    endtask
    initial begin
        nrst = 1'b0;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        `CHK("ready_after_reset", 1'b1, req_ready)
        s_route();
        s_pipe();
        s_dep();
        s_reset();
        s_pipe();
        wrap_up();
    end
endmodule // tb_integer_branch_issue_timing
